// ===== inc/uefc_consts.svh
// offsets, field positions, reset values and write masks of the enhanced control block
// assumes byte addressing on a 32-bit avalon-mm register port
`ifndef UEFC_CONSTS_SVH
`define UEFC_CONSTS_SVH
`define UEFC_OFF_MODEM 5'h00
`define UEFC_OFF_SCRATCH 5'h04
`define UEFC_OFF_FEATURE 5'h08
`define UEFC_OFF_ENHANCED 5'h0c
`define UEFC_OFF_INT_ENABLE 5'h10
`define UEFC_OFF_MODEM_CTRL 5'h14
`define UEFC_RST_SCRATCH 8'hff
`define UEFC_RST_ZERO 8'h00
`define UEFC_LC_GATED_MASK 8'hfc
`define UEFC_IER_GATED_MASK 8'he0
`define UEFC_MCR_GATED_MASK 8'hec
`define UEFC_LC_TXDIS 3
`define UEFC_LC_RXDIS 2
`define UEFC_LC_NINE_BIT 0
`define UEFC_FC_AUTO485 5
`define UEFC_FC_IR_INV 4
`define UEFC_FC_WR_MASK 8'h30
`define UEFC_EF_AUTO_CTS 7
`define UEFC_EF_AUTO_RTS 6
`define UEFC_EF_SPECIAL 5
`define UEFC_EF_ENH 4
`define UEFC_IER_MODEM 3
`define UEFC_IER_TX 1
`define UEFC_MCR_FLOW_SEL 2
`define UEFC_MCR_RTS 1
`define UEFC_MCR_DTR 0
`define UEFC_CMP_PAIR2 2'b01
`endif

// ===== inc/uefc_pkg.sv
// types shared by the enhanced control block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package uefc_pkg;
  typedef enum logic [1:0] {
    UEFC_RX_ON = 2'b00,
    UEFC_RX_LAST = 2'b01,
    UEFC_RX_OFF = 2'b10,
    UEFC_RX_WAIT_IDLE = 2'b11
  } uefc_rx_state_t;
  typedef enum logic [1:0] {
    UEFC_TX_IDLE = 2'b00,
    UEFC_TX_BUSY = 2'b01,
    UEFC_TX_TURN = 2'b10
  } uefc_tx_state_t;
endpackage
`default_nettype wire

// ===== logic/uefc_core.sv
// per-channel enhanced control: modem deltas, turnaround, path control, features
// assumes a uart core on clk_i giving bit ticks, fifo levels and character strobes
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`default_nettype none
`include "uefc_consts.svh"
module uefc_core (
  input wire logic clk_i, // 40 mhz channel clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic ce_i, // clock enable, freezes all state
  input wire logic [4:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic cts_n_i, // clear-to-send pin
  input wire logic dsr_n_i, // data-set-ready pin
  input wire logic ir_rx_i, // encoded infrared receive pin
  input wire logic rx_line_i, // receive line, idle high
  output logic rts_n_o, // request-to-send pin
  output logic dtr_n_o, // terminal-ready pin
  output logic ir_rx_o, // receive data, polarity corrected
  input wire logic bit_tick_i, // one pulse per bit time
  input wire logic tx_load_i, // byte loaded into holding/fifo
  input wire logic tx_fifo_empty_i, // holding register or fifo empty
  input wire logic tx_shift_empty_i, // shifter empty, stop bit sent
  output logic tx_halt_o, // shifter must not start a character
  input wire logic rx_busy_i, // receiver inside a character
  input wire logic rx_char_valid_i, // received character strobe
  input wire logic [7:0] rx_char_i, // received character
  input wire logic [7:0] xoff2_i, // second xoff character
  output logic rx_enable_o, // receiver may start a character
  output logic rx_store_o, // push last character into fifo
  output logic special_char_o, // special character detected pulse
  output logic xoff_detect_o, // xoff detected pulse
  input wire logic rx_at_trigger_i, // rx fifo at trigger level
  input wire logic rx_above_upper_i, // rx fifo at upper trigger
  input wire logic rx_below_lower_i, // rx fifo below lower trigger
  output logic rx_trigger_int_o, // rx trigger interrupt request
  output logic modem_int_o, // modem status interrupt request
  output logic tx_int_o, // transmit interrupt request
  output logic nine_bit_o, // multidrop mode
  output logic [3:0] sw_flow_sel_o, // software flow selection
  output logic dual_char_o, // two-character xon/xoff pairs
  output logic [2:0] ier_enh_o // enhanced interrupt enables
);
  // ****************************************
  // functions
  // ****************************************
  // gated fields keep old value unless the enhanced bit is set
  function automatic logic [7:0] gated_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask, input logic enh);
    gated_merge = enh ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  // infrared pin shares the filter; it rests low, the others rest high
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] pin_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 4'h7;
      sync2_reg <= 4'h7;
      sync3_reg <= 4'h7;
      pin_reg <= 4'h7;
    end else if (ce_i) begin
      sync1_reg <= {ir_rx_i, rx_line_i, dsr_n_i, cts_n_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 4; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_reg[i] <= sync3_reg[i];
        end
      end
    end
  end
  logic cts_n_s;
  logic dsr_n_s;
  logic rx_line_s;
  assign cts_n_s = pin_reg[0];
  assign dsr_n_s = pin_reg[1];
  assign rx_line_s = pin_reg[2];

  // ****************************************
  // register port
  // ****************************************
  logic ack_reg;
  logic req;
  logic wr_go;
  logic rd_go;
  assign req = avs_read_i | avs_write_i;
  // one wait cycle: data are ready at the second edge of every access
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_go = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign rd_go = avs_read_i & ack_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  logic [7:0] lc_reg;
  logic [7:0] scratch_reg;
  logic [7:0] fc_reg;
  logic [7:0] ef_reg;
  logic [7:0] ier_reg;
  logic [7:0] mcr_reg;
  logic [1:0] delta_reg;
  logic [7:0] wd;
  logic enh;
  assign wd = avs_writedata_i[7:0];
  assign enh = ef_reg[`UEFC_EF_ENH];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lc_reg <= `UEFC_RST_ZERO;
      scratch_reg <= `UEFC_RST_SCRATCH;
      fc_reg <= `UEFC_RST_ZERO;
      ef_reg <= `UEFC_RST_ZERO;
      ier_reg <= `UEFC_RST_ZERO;
      mcr_reg <= `UEFC_RST_ZERO;
    end else if (ce_i && wr_go) begin
      case (avs_address_i)
        `UEFC_OFF_MODEM: begin
          lc_reg <= gated_merge(lc_reg, wd & 8'hfd, `UEFC_LC_GATED_MASK, enh);
        end
        `UEFC_OFF_SCRATCH: scratch_reg <= wd;
        `UEFC_OFF_FEATURE: fc_reg <= wd & `UEFC_FC_WR_MASK;
        `UEFC_OFF_ENHANCED: ef_reg <= wd;
        `UEFC_OFF_INT_ENABLE: begin
          ier_reg <= gated_merge(ier_reg, wd, `UEFC_IER_GATED_MASK, enh);
        end
        `UEFC_OFF_MODEM_CTRL: begin
          mcr_reg <= gated_merge(mcr_reg, wd, `UEFC_MCR_GATED_MASK, enh);
        end
        default: begin
        end
      endcase
    end
  end

  // delta flags: a change in the clearing read cycle survives
  logic [1:0] pin_old_reg;
  logic [1:0] change;
  logic rd_status;
  assign change = pin_old_reg ^ {dsr_n_s, cts_n_s};
  assign rd_status = rd_go && avs_address_i == `UEFC_OFF_MODEM;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_old_reg <= 2'h3;
      delta_reg <= 2'h0;
    end else if (ce_i) begin
      pin_old_reg <= {dsr_n_s, cts_n_s};
      delta_reg <= change | (rd_status ? 2'h0 : delta_reg);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0;
    end else if (ce_i && avs_read_i && !ack_reg) begin
      case (avs_address_i)
        `UEFC_OFF_MODEM: avs_readdata_o <= {24'h0, 2'h0, ~dsr_n_s, ~cts_n_s, 2'h0, delta_reg};
        `UEFC_OFF_SCRATCH: avs_readdata_o <= {24'h0, scratch_reg};
        `UEFC_OFF_FEATURE: avs_readdata_o <= {24'h0, fc_reg};
        `UEFC_OFF_ENHANCED: avs_readdata_o <= {24'h0, ef_reg};
        `UEFC_OFF_INT_ENABLE: avs_readdata_o <= {24'h0, ier_reg};
        `UEFC_OFF_MODEM_CTRL: avs_readdata_o <= {24'h0, mcr_reg};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // transmit direction and flow
  // ****************************************
  uefc_pkg::uefc_tx_state_t tx_state_reg;
  logic [3:0] turn_cnt_reg;
  logic [3:0] delay;
  logic tx_done;
  logic dir_reg;
  assign delay = lc_reg[7:4];
  assign tx_done = tx_fifo_empty_i & tx_shift_empty_i & ~tx_load_i;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_state_reg <= uefc_pkg::UEFC_TX_IDLE;
      turn_cnt_reg <= 4'h0;
      dir_reg <= 1'b0;
    end else if (ce_i) begin
      case (tx_state_reg)
        uefc_pkg::UEFC_TX_IDLE: begin
          if (tx_load_i) begin
            dir_reg <= 1'b1;
            tx_state_reg <= uefc_pkg::UEFC_TX_BUSY;
          end
        end
        uefc_pkg::UEFC_TX_BUSY: begin
          if (tx_done && delay == 4'h0) begin
            dir_reg <= 1'b0;
            tx_state_reg <= uefc_pkg::UEFC_TX_IDLE;
          end else if (tx_done) begin
            turn_cnt_reg <= 4'h0;
            tx_state_reg <= uefc_pkg::UEFC_TX_TURN;
          end
        end
        uefc_pkg::UEFC_TX_TURN: begin
          if (tx_load_i) begin
            tx_state_reg <= uefc_pkg::UEFC_TX_BUSY;
          end else if (bit_tick_i && turn_cnt_reg + 4'h1 == delay) begin
            dir_reg <= 1'b0;
            tx_state_reg <= uefc_pkg::UEFC_TX_IDLE;
          end else if (bit_tick_i) begin
            turn_cnt_reg <= turn_cnt_reg + 4'h1;
          end
        end
        default: tx_state_reg <= uefc_pkg::UEFC_TX_IDLE;
      endcase
    end
  end

  // auto output flow holds the selected pin deasserted between the triggers
  logic flow_hold_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flow_hold_reg <= 1'b0;
    end else if (ce_i) begin
      if (!ef_reg[`UEFC_EF_AUTO_RTS]) begin
        flow_hold_reg <= 1'b0;
      end else if (rx_above_upper_i) begin
        flow_hold_reg <= 1'b1;
      end else if (rx_below_lower_i) begin
        flow_hold_reg <= 1'b0;
      end
    end
  end

  logic use_dtr;
  logic auto_out;
  logic rts_n_next;
  logic dtr_n_next;
  assign use_dtr = mcr_reg[`UEFC_MCR_FLOW_SEL];
  assign auto_out = ef_reg[`UEFC_EF_AUTO_RTS];
  always_comb begin
    rts_n_next = ~mcr_reg[`UEFC_MCR_RTS];
    dtr_n_next = ~mcr_reg[`UEFC_MCR_DTR];
    if (auto_out && !use_dtr) begin
      rts_n_next = ~mcr_reg[`UEFC_MCR_RTS] | flow_hold_reg;
    end
    if (auto_out && use_dtr) begin
      dtr_n_next = ~mcr_reg[`UEFC_MCR_DTR] | flow_hold_reg;
    end
    // rs485 drives the pin level directly: high while sending
    if (fc_reg[`UEFC_FC_AUTO485]) begin
      rts_n_next = dir_reg;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else if (ce_i) begin
      rts_n_o <= rts_n_next;
      dtr_n_o <= dtr_n_next;
    end
  end

  // halt only blocks the next start; a character in flight completes
  assign tx_halt_o = lc_reg[`UEFC_LC_TXDIS]
    | (ef_reg[`UEFC_EF_AUTO_CTS] & (use_dtr ? dsr_n_s : cts_n_s));

  // ****************************************
  // receive path
  // ****************************************
  uefc_pkg::uefc_rx_state_t rx_state_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state_reg <= uefc_pkg::UEFC_RX_ON;
    end else if (ce_i) begin
      case (rx_state_reg)
        uefc_pkg::UEFC_RX_ON: begin
          if (lc_reg[`UEFC_LC_RXDIS]) begin
            rx_state_reg <= uefc_pkg::UEFC_RX_LAST;
          end
        end
        uefc_pkg::UEFC_RX_LAST: begin
          if (rx_char_valid_i) begin
            rx_state_reg <= uefc_pkg::UEFC_RX_OFF;
          end
        end
        uefc_pkg::UEFC_RX_OFF: begin
          if (!lc_reg[`UEFC_LC_RXDIS]) begin
            rx_state_reg <= uefc_pkg::UEFC_RX_WAIT_IDLE;
          end
        end
        uefc_pkg::UEFC_RX_WAIT_IDLE: begin
          // a start mid-frame would load garbage, so wait for idle high
          if (lc_reg[`UEFC_LC_RXDIS]) begin
            rx_state_reg <= uefc_pkg::UEFC_RX_OFF;
          end else if (rx_line_s && !rx_busy_i) begin
            rx_state_reg <= uefc_pkg::UEFC_RX_ON;
          end
        end
        default: rx_state_reg <= uefc_pkg::UEFC_RX_ON;
      endcase
    end
  end
  assign rx_enable_o = rx_state_reg == uefc_pkg::UEFC_RX_ON
    || rx_state_reg == uefc_pkg::UEFC_RX_LAST;

  logic match;
  logic pair2;
  assign match = ef_reg[`UEFC_EF_SPECIAL] && rx_char_i == xoff2_i;
  assign pair2 = ef_reg[1:0] == `UEFC_CMP_PAIR2;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_store_o <= 1'b0;
      special_char_o <= 1'b0;
      xoff_detect_o <= 1'b0;
    end else if (ce_i) begin
      rx_store_o <= rx_char_valid_i & ~(match & pair2);
      special_char_o <= rx_char_valid_i & match;
      xoff_detect_o <= rx_char_valid_i & match & pair2;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ir_rx_o <= 1'b0;
      modem_int_o <= 1'b0;
      tx_int_o <= 1'b0;
      rx_trigger_int_o <= 1'b0;
    end else if (ce_i) begin
      ir_rx_o <= fc_reg[`UEFC_FC_IR_INV] ? ~pin_reg[3] : pin_reg[3];
      modem_int_o <= ier_reg[`UEFC_IER_MODEM] & (|delta_reg);
      tx_int_o <= ier_reg[`UEFC_IER_TX] & (fc_reg[`UEFC_FC_AUTO485] ?
                  (tx_fifo_empty_i & tx_shift_empty_i) : tx_fifo_empty_i);
      rx_trigger_int_o <= auto_out & rx_at_trigger_i;
    end
  end
  assign nine_bit_o = lc_reg[`UEFC_LC_NINE_BIT];
  assign sw_flow_sel_o = ef_reg[3:0];
  assign dual_char_o = ef_reg[3] & ef_reg[2];
  assign ier_enh_o = ier_reg[7:5];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_scratch_write;
    wr_go && ce_i && avs_address_i == `UEFC_OFF_SCRATCH |=> scratch_reg == $past(wd);
  endproperty
  a_scratch_write: assert property (p_scratch_write) else $error("scratch lost");
  property p_gate;
    wr_go && ce_i && !enh && avs_address_i == `UEFC_OFF_MODEM |=> $stable(lc_reg[7:2]);
  endproperty
  a_gate: assert property (p_gate) else $error("gated bits changed");
  property p_delta;
    ce_i && change[0] |=> delta_reg[0];
  endproperty
  a_delta: assert property (p_delta) else $error("delta missed");
  property p_halt;
    lc_reg[`UEFC_LC_TXDIS] |-> tx_halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("tx not halted");
  property p_rs485_up;
    ce_i && fc_reg[`UEFC_FC_AUTO485] && tx_load_i && tx_state_reg == uefc_pkg::UEFC_TX_IDLE
      |=> ##1 rts_n_o || !fc_reg[`UEFC_FC_AUTO485] || !ce_i;
  endproperty
  a_rs485_up: assert property (p_rs485_up) else $error("rts not raised");
  property p_rs485_zero;
    ce_i && tx_state_reg == uefc_pkg::UEFC_TX_BUSY && tx_done && delay == 4'h0 |=> !dir_reg;
  endproperty
  a_rs485_zero: assert property (p_rs485_zero) else $error("rts held");
  property p_rx_off;
    rx_state_reg == uefc_pkg::UEFC_RX_OFF |-> !rx_enable_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx still on");
  property p_no_store;
    ce_i && rx_char_valid_i && match && pair2 |=> !rx_store_o && special_char_o && xoff_detect_o;
  endproperty
  a_no_store: assert property (p_no_store) else $error("xoff2 stored");
  property p_ir;
    ce_i && fc_reg[`UEFC_FC_IR_INV] && $stable(fc_reg) |=> ir_rx_o == ~$past(pin_reg[3]);
  endproperty
  a_ir: assert property (p_ir) else $error("ir polarity");
  c_turn: cover property (tx_state_reg == uefc_pkg::UEFC_TX_TURN ##[1:300] !dir_reg);
  c_rx_last: cover property (rx_state_reg == uefc_pkg::UEFC_RX_LAST ##[1:300] rx_char_valid_i);
  c_special: cover property (special_char_o);
  c_flow_hold: cover property (flow_hold_reg && !rts_n_next);
endmodule // uefc_core
`default_nettype wire

// ===== logic/uefc_unused_placeholder_none.sv
// intentionally minimal: no further logic lives outside uefc_core
`default_nettype none
`default_nettype wire

// ===== tb/uefc_remote.sv
// remote serial device model: handshake pins, infrared pin and an idle receive line
// assumes the bench steers the handshake levels and the infrared symbol
`default_nettype none
module uefc_remote (
  input wire logic clk_i, // bench clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic [1:0] hold_i, // bit0 cts, bit1 dsr: remote not ready
  input wire logic ir_bit_i, // infrared symbol to send
  output logic cts_n_o, // clear-to-send pin
  output logic dsr_n_o, // data-set-ready pin
  output logic rx_line_o, // serial line towards the block
  output logic ir_o // encoded infrared pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // pins
  // ********
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cts_n_o <= 1'b1;
      dsr_n_o <= 1'b1;
      ir_o <= 1'b0;
    end else begin
      cts_n_o <= hold_i[0];
      dsr_n_o <= hold_i[1];
      ir_o <= ir_bit_i;
    end
  end
  // no frames are sent, so the line rests at mark for a clean re-enable
  assign rx_line_o = 1'b1;
endmodule // uefc_remote
`default_nettype wire

// ===== tb/uefc_core_tb.sv
// self-checking bench: registers, gating, modem pins, rs485 turnaround, compare
// assumes the remote model on the modem pins; the bench plays the uart core side
`default_nettype none
`include "uefc_consts.svh"
module uefc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, ce_i;
  logic [3:0] avs_byteenable_i, sw_flow_sel_o, d;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic cts_n_i, dsr_n_i, ir_rx_i, rx_line_i, rts_n_o, dtr_n_o, ir_rx_o, ir_bit;
  logic bit_tick_i, tx_load_i, tx_fifo_empty_i, tx_shift_empty_i, tx_halt_o, rx_busy_i;
  logic rx_char_valid_i, rx_enable_o, rx_store_o, special_char_o, xoff_detect_o, dual_char_o;
  logic rx_at_trigger_i, rx_above_upper_i, rx_below_lower_i, rx_trigger_int_o;
  logic modem_int_o, tx_int_o, nine_bit_o;
  logic [1:0] hold;
  logic [2:0] ier_enh_o;
  logic [7:0] rx_char_i, xoff2_i, q, v, lc;
  int error_cnt, checks, seed, i, s;
  uefc_core uut (.*);
  uefc_remote far (.clk_i(clk_i), .reset_n_i(reset_n_i), .hold_i(hold), .ir_bit_i(ir_bit),
    .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .rx_line_o(rx_line_i), .ir_o(ir_rx_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ********
  // helpers
  // ********
  function automatic logic [7:0] stat_exp(input logic cn, dn, dc, dd);
    return {2'b00, ~dn, ~cn, 2'b00, dd, dc};
  endfunction
  // gated bits 7:2 keep their old value while the enhanced bit is clear
  function automatic logic [7:0] lc_exp(input logic [7:0] o, n, input logic e);
    return {(e ? n[7:2] : o[7:2]), 1'b0, n[0]};
  endfunction
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, dat};
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 64) begin
      error_cnt++;
      results();
    end
    @(negedge clk_i);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk_reg(nm, e, q);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ********
  // sequence
  // ********
  initial begin
    seed = 32'h6a501cf1;
    {error_cnt, checks} = '0;
    {reset_n_i, avs_read_i, avs_write_i, bit_tick_i, tx_load_i, rx_busy_i, ir_bit} = '0;
    {rx_char_valid_i, rx_at_trigger_i, rx_above_upper_i, rx_below_lower_i} = '0;
    {avs_address_i, avs_writedata_i, rx_char_i, xoff2_i} = '0;
    {ce_i, tx_fifo_empty_i, tx_shift_empty_i, hold} = 5'h1f;
    avs_byteenable_i = 4'h1;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd("status", `UEFC_OFF_MODEM, 8'h00);
    rd("scratch", `UEFC_OFF_SCRATCH, `UEFC_RST_SCRATCH);
    rd("feature", `UEFC_OFF_FEATURE, 8'h00);
    rd("enhanced", `UEFC_OFF_ENHANCED, 8'h00);
    bus(1'b1, 5'h1c, 8'h5a);
    rd("unmapped", 5'h1c, 8'h00);
    bus(1'b1, `UEFC_OFF_FEATURE, 8'hff);
    rd("feature", `UEFC_OFF_FEATURE, 8'h30);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      bus(1'b1, `UEFC_OFF_SCRATCH, v);
      rd("scratch", `UEFC_OFF_SCRATCH, v);
    end
    $display("test registers done");
    lc = 8'h00;
    for (i = 0; i < 8; i++) begin
      s = (i < 2) ? i : $random(seed) & 1;
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h0a : 8'($random(seed));
      bus(1'b1, `UEFC_OFF_ENHANCED, {3'b000, s[0], 4'h0});
      bus(1'b1, `UEFC_OFF_MODEM, v);
      lc = lc_exp(lc, v, s[0]);
      chk_pin("tx_halt_o", lc[3], tx_halt_o);
      chk_pin("nine_bit_o", lc[0], nine_bit_o);
    end
    bus(1'b1, `UEFC_OFF_ENHANCED, 8'h10);
    bus(1'b1, `UEFC_OFF_MODEM, 8'h00);
    $display("test gating done");
    bus(1'b1, `UEFC_OFF_INT_ENABLE, 8'hea);
    chk_reg("ier_enh_o", 8'h07, {5'h00, ier_enh_o});
    @(posedge clk_i);
    hold <= 2'b00;
    wt(10);
    chk_pin("modem_int_o", 1'b1, modem_int_o);
    rd("status", `UEFC_OFF_MODEM, stat_exp(1'b0, 1'b0, 1'b1, 1'b1));
    rd("status", `UEFC_OFF_MODEM, stat_exp(1'b0, 1'b0, 1'b0, 1'b0));
    chk_pin("modem_int_o", 1'b0, modem_int_o);
    bus(1'b1, `UEFC_OFF_ENHANCED, 8'h90);
    for (s = 0; s < 2; s++) begin
      bus(1'b1, `UEFC_OFF_MODEM_CTRL, {5'h00, s[0], 2'b00});
      for (i = 0; i < 4; i++) begin
        @(posedge clk_i);
        hold <= i[1:0];
        wt(10);
        chk_pin("tx_halt_o", i[s], tx_halt_o);
      end
    end
    $display("test modem pins done");
    bus(1'b1, `UEFC_OFF_ENHANCED, 8'h10);
    bus(1'b1, `UEFC_OFF_FEATURE, 8'h20);
    for (i = 0; i < 4; i++) begin
      d = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
      bus(1'b1, `UEFC_OFF_MODEM, {d, 4'h0});
      @(posedge clk_i);
      {tx_load_i, tx_fifo_empty_i, tx_shift_empty_i} <= 3'b100;
      @(posedge clk_i);
      {tx_load_i, tx_fifo_empty_i} <= 2'b01;
      wt(2);
      chk_pin("rts_n_o", 1'b1, rts_n_o);
      chk_pin("tx_int_o", 1'b0, tx_int_o);
      @(posedge clk_i);
      tx_shift_empty_i <= 1'b1;
      repeat (d) begin
        wt(2);
        chk_pin("rts_n_o", 1'b1, rts_n_o);
        @(posedge clk_i);
        bit_tick_i <= 1'b1;
        @(posedge clk_i);
        bit_tick_i <= 1'b0;
      end
      wt(3);
      chk_pin("rts_n_o", 1'b0, rts_n_o);
      chk_pin("tx_int_o", 1'b1, tx_int_o);
    end
    bus(1'b1, `UEFC_OFF_FEATURE, 8'h00);
    @(posedge clk_i);
    tx_shift_empty_i <= 1'b0;
    wt(3);
    chk_pin("tx_int_o", 1'b1, tx_int_o);
    @(posedge clk_i);
    tx_shift_empty_i <= 1'b1;
    $display("test turnaround done");
    for (i = 0; i < 6; i++) begin
      bus(1'b1, `UEFC_OFF_FEATURE, {3'b000, i[0], 4'h0});
      @(posedge clk_i);
      ir_bit <= 1'($random(seed));
      wt(8);
      chk_pin("ir_rx_o", ir_bit ^ i[0], ir_rx_o);
    end
    // clock enable low must freeze the inverted infrared path
    @(posedge clk_i);
    ce_i <= 1'b0;
    ir_bit <= ~ir_bit;
    wt(8);
    chk_pin("ir_rx_o", ir_bit, ir_rx_o);
    @(posedge clk_i);
    ce_i <= 1'b1;
    wt(8);
    chk_pin("ir_rx_o", ~ir_bit, ir_rx_o);
    bus(1'b1, `UEFC_OFF_MODEM, 8'h04);
    chk_pin("rx_enable_o", 1'b1, rx_enable_o);
    @(posedge clk_i);
    rx_char_valid_i <= 1'b1;
    @(posedge clk_i);
    rx_char_valid_i <= 1'b0;
    wt(2);
    chk_pin("rx_enable_o", 1'b0, rx_enable_o);
    bus(1'b1, `UEFC_OFF_MODEM, 8'h00);
    wt(8);
    chk_pin("rx_enable_o", 1'b1, rx_enable_o);
    $display("test receiver done");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `UEFC_OFF_ENHANCED, 8'h30);
      bus(1'b1, `UEFC_OFF_ENHANCED, i[1] ? 8'h31 : 8'h30);
      v = 8'($random(seed));
      @(posedge clk_i);
      xoff2_i <= v;
      rx_char_i <= i[0] ? v : v ^ 8'h01;
      rx_char_valid_i <= 1'b1;
      @(posedge clk_i);
      rx_char_valid_i <= 1'b0;
      @(negedge clk_i);
      chk_pin("special_char_o", i[0], special_char_o);
      chk_pin("rx_store_o", !(i[0] & i[1]), rx_store_o);
      chk_pin("xoff_detect_o", i[0] & i[1], xoff_detect_o);
    end
    bus(1'b1, `UEFC_OFF_ENHANCED, 8'h10);
    bus(1'b1, `UEFC_OFF_ENHANCED, 8'h1c);
    chk_pin("dual_char_o", 1'b1, dual_char_o);
    chk_reg("sw_flow_sel_o", 8'h0c, {4'h0, sw_flow_sel_o});
    $display("test compare done");
    bus(1'b1, `UEFC_OFF_ENHANCED, 8'h50);
    bus(1'b1, `UEFC_OFF_MODEM_CTRL, 8'h02);
    wt(1);
    chk_pin("rts_n_o", 1'b0, rts_n_o);
    chk_pin("dtr_n_o", 1'b1, dtr_n_o);
    @(posedge clk_i);
    {rx_above_upper_i, rx_at_trigger_i} <= 2'b11;
    wt(4);
    chk_pin("rts_n_o", 1'b1, rts_n_o);
    chk_pin("rx_trigger_int_o", 1'b1, rx_trigger_int_o);
    @(posedge clk_i);
    {rx_above_upper_i, rx_below_lower_i, rx_at_trigger_i} <= 3'b010;
    wt(4);
    chk_pin("rts_n_o", 1'b0, rts_n_o);
    chk_pin("rx_trigger_int_o", 1'b0, rx_trigger_int_o);
    bus(1'b1, `UEFC_OFF_MODEM_CTRL, 8'h05);
    wt(1);
    chk_pin("dtr_n_o", 1'b0, dtr_n_o);
    @(posedge clk_i);
    rx_above_upper_i <= 1'b1;
    wt(4);
    chk_pin("dtr_n_o", 1'b1, dtr_n_o);
    chk_pin("rts_n_o", 1'b1, rts_n_o);
    $display("test output flow done");
    bus(1'b1, `UEFC_OFF_ENHANCED, 8'h00);
    bus(1'b1, `UEFC_OFF_INT_ENABLE, 8'h0a);
    chk_reg("ier_enh_o", 8'h07, {5'h00, ier_enh_o});
    rd("int_enable", `UEFC_OFF_INT_ENABLE, 8'hea);
    $display("test latch done");
    results();
  end
endmodule // uefc_core_tb
`default_nettype wire
